// >>> hdl/timer_readback_pkg.sv
// Shared constants and types for the timer count and status read-back logic
package timer_readback_pkg;
  // Port select codes on the host port
  localparam logic [1:0] port_counter0 = 2'h0;
  localparam logic [1:0] port_counter1 = 2'h1;
  localparam logic [1:0] port_counter2 = 2'h2;
  localparam logic [1:0] command_port = 2'h3;
  // Command word field positions
  localparam int select_high_pos = 7;
  localparam int select_low_pos = 6;
  localparam int access_high_pos = 5;
  localparam int access_low_pos = 4;
  localparam int count_bit_pos = 5;
  localparam int status_bit_pos = 4;
  localparam int rb_counter0_pos = 1;
  localparam int status_out_pos = 7;
  localparam int status_null_pos = 6;
  // Special select and access codes
  localparam logic [1:0] select_readback = 2'h3;
  localparam logic [1:0] access_latch = 2'h0;
  localparam logic [1:0] access_low_only = 2'h1;
  localparam logic [1:0] access_high_only = 2'h2;
  localparam logic [1:0] access_low_high = 2'h3;
  // Reset values and number of counters
  localparam logic [5:0] mode_reset = 6'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam int num_counters = 3;
  // Host recovery in cycles, one less than the strobe width, long enough for the device strobe filter
  localparam logic [3:0] strobe_cycles = 4'h6;
  // Host side bus transaction state
  typedef enum logic [1:0] {host_idle, host_setup, host_strobe, host_done} host_state_t;
endpackage

// >>> hdl/timer_port_if.sv
// Parallel host port joining the bus master end and the timer read-back end
`timescale 1ns/10ps
`default_nettype none
interface timer_port_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic port_select_high;
  logic port_select_low;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  // Host drives strobes and its data lanes
  modport host (output cs_n, rd_n, wr_n, port_select_high, port_select_low, host_data,
    host_data_oe, input dev_data, dev_data_oe);
  // Device answers with read data
  modport device (input cs_n, rd_n, wr_n, port_select_high, port_select_low, host_data,
    host_data_oe, output dev_data, dev_data_oe);
endinterface
`default_nettype wire

// >>> hdl/timer_readback.sv
// Device end: latch and read-back logic of a three-channel 16-bit interval timer
// Contract
// R01: Command port latch uses select bits D7:D6, with D5:D4 zero
// R02: Latch freezes count until read or reprogram
// R03: Second latch before read is ignored
// R04: Latch commands keep mode settings unchanged
// R05: Two-byte reads survive interleaved other accesses
// R06: Separate read and write byte pointers
// R07: Software must not interleave two-byte readers
// R08: Read-back bits D1..D3 select counters 0..2
// R09: Read-back D5 low latches selected counts
// R10: Repeated count read-back ignored until read
// R11: Read-back D4 low latches status byte
// R12: Status holds out, null flag, mode bits
// R13: Null flag set by control/count, cleared load
// R14: Two-byte write sets null on high byte
// R15: Latched count shows old counting element
// R16: Repeated status latch ignored until read
// R17: Combined read-back latches each part separately
// R18: Status read first, then count, then live
// R19: Strobe and port select decoding table
// R20: Select code 11 means read-back command
// R21: Access code 00 means counter latch
// R22: Two-byte transfers go low byte first
// R23: Status always one read, then released
`timescale 1ns/10ps
`default_nettype none
module timer_readback
  import timer_readback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host port
  timer_port_if.device port,
  // Counting elements and output pins of the three counters
  input wire logic [15:0] live_count [num_counters],
  input wire logic [num_counters-1:0] out_level,
  input wire logic [num_counters-1:0] count_loaded,
  // Count register outputs towards the counting elements
  output logic [15:0] count_load_register [num_counters],
  output logic [num_counters-1:0] count_written,
  output logic [5:0] mode_bits [num_counters]
);
  // Per counter state
  typedef struct packed {
    logic [5:0] mode;         // Last control word bits D5..D0
    logic [15:0] latch;       // Output latch contents
    logic count_latched;      // Latch frozen
    logic [7:0] status;       // Latched status byte
    logic status_latched;     // Status waiting to be read
    logic null_count;         // Pending load flag
    logic read_high;          // Read pointer at high byte
    logic write_high;         // Write pointer at high byte
    logic [15:0] load_value;  // Count register
    logic written;            // One-cycle pulse on full count write
  } chan_t;
  typedef struct packed {
    chan_t [num_counters-1:0] ch;
    logic [2:0] rd_sync;      // Synchroniser on read strobe
    logic [2:0] wr_sync;      // Synchroniser on write strobe
    logic rd_level_n;         // Filtered read strobe level, low while active
    logic wr_level_n;         // Filtered write strobe level, low while active
    logic [7:0] data_out;     // Read data driven to the host
    logic data_oe;            // Data bus enable
  } state_t;

  state_t cur;
  state_t next_cur;

  // Strobe level after the second and third stages agree
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // Byte picked by the read pointer for a given access format
  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic [1:0] fmt,
                                           input logic hi);
    if (fmt == access_high_only || (fmt == access_low_high && hi))
      pick_byte = v[15:8];
    else
      pick_byte = v[7:0];
  endfunction

  logic rd_settled_n; // Read strobe level this cycle after the filter
  logic wr_settled_n; // Write strobe level this cycle after the filter
  logic rd_edge;
  logic wr_edge;
  logic [1:0] sel;
  logic [7:0] din;

  // Strobe decode: active only with chip select low, one strobe at a time
  always_comb
  begin
    rd_settled_n = agreed(cur.rd_sync, cur.rd_level_n);
    wr_settled_n = agreed(cur.wr_sync, cur.wr_level_n);
    sel = {port.port_select_high, port.port_select_low};
    din = port.host_data;
    // Act once on the falling edge of the filtered strobe, so a bounce never acts twice
    rd_edge = cur.rd_level_n && !rd_settled_n && !port.cs_n; // R19
    wr_edge = cur.wr_level_n && !wr_settled_n && !port.cs_n; // R19
    if (rd_edge && wr_edge)
    begin
      // Both strobes together is not a legal access
      rd_edge = 1'b0;
      wr_edge = 1'b0;
    end
  end

  // Next state
  always_comb
  begin
    logic [1:0] fmt;
    logic [15:0] shown;
    fmt = 2'h0;
    shown = 16'h0000;
    next_cur = cur;
    next_cur.rd_sync = {cur.rd_sync[1:0], port.rd_n};
    next_cur.wr_sync = {cur.wr_sync[1:0], port.wr_n};
    next_cur.rd_level_n = rd_settled_n;
    next_cur.wr_level_n = wr_settled_n;
    // Drive data only while a counter read is in progress
    next_cur.data_oe = !port.cs_n && !port.rd_n && port.wr_n && sel != command_port; // R19
    for (int i = 0; i < num_counters; i++)
    begin
      next_cur.ch[i].written = 1'b0;
      // Counting element took the count register
      if (count_loaded[i])
        next_cur.ch[i].null_count = 1'b0; // R13
      // Unlatched output latch follows the counting element
      if (!cur.ch[i].count_latched)
        next_cur.ch[i].latch = live_count[i]; // R02 R15
    end
    // Host read of a counter data port
    if (rd_edge && sel != command_port)
    begin
      fmt = cur.ch[sel].mode[5:4];
      shown = cur.ch[sel].count_latched ? cur.ch[sel].latch : live_count[sel];
      if (cur.ch[sel].status_latched)
      begin
        next_cur.data_out = cur.ch[sel].status; // R18 R23
        next_cur.ch[sel].status_latched = 1'b0; // R23
      end
      else
      begin
        next_cur.data_out = pick_byte(shown, fmt, cur.ch[sel].read_high); // R22
        if (fmt == access_low_high && !cur.ch[sel].read_high)
          next_cur.ch[sel].read_high = 1'b1; // R05 R06
        else
        begin
          next_cur.ch[sel].read_high = 1'b0;
          next_cur.ch[sel].count_latched = 1'b0; // R02
        end
      end
    end
    // Host write of a counter count register
    if (wr_edge && sel != command_port)
    begin
      fmt = cur.ch[sel].mode[5:4];
      if (fmt == access_low_high && !cur.ch[sel].write_high)
      begin
        next_cur.ch[sel].load_value[7:0] = din; // R22
        next_cur.ch[sel].write_high = 1'b1; // R06 R14
      end
      else
      begin
        if (fmt == access_high_only || fmt == access_low_high)
          next_cur.ch[sel].load_value[15:8] = din;
        else
          next_cur.ch[sel].load_value[7:0] = din;
        if (fmt == access_high_only)
          next_cur.ch[sel].load_value[7:0] = data_reset;
        if (fmt == access_low_only)
          next_cur.ch[sel].load_value[15:8] = data_reset;
        next_cur.ch[sel].write_high = 1'b0;
        next_cur.ch[sel].null_count = 1'b1; // R13 R14
        next_cur.ch[sel].written = 1'b1;
      end
    end
    // Command port write
    if (wr_edge && sel == command_port)
    begin
      if (din[select_high_pos:select_low_pos] == select_readback)
      begin
        // Read-back applies to each selected counter
        for (int i = 0; i < num_counters; i++)
          if (din[rb_counter0_pos + i]) // R08 R20
          begin
            if (!din[count_bit_pos] && !cur.ch[i].count_latched)
            begin
              next_cur.ch[i].count_latched = 1'b1; // R09 R10 R17
              next_cur.ch[i].latch = live_count[i]; // R15
            end
            if (!din[status_bit_pos] && !cur.ch[i].status_latched)
            begin
              next_cur.ch[i].status_latched = 1'b1; // R11 R16 R17
              next_cur.ch[i].status = {out_level[i], cur.ch[i].null_count,
                                       cur.ch[i].mode}; // R12
            end
          end
      end
      else if (din[access_high_pos:access_low_pos] == access_latch)
      begin
        // Counter latch command, mode settings untouched
        if (!cur.ch[din[select_high_pos:select_low_pos]].count_latched)
        begin
          next_cur.ch[din[select_high_pos:select_low_pos]].count_latched = 1'b1; // R01 R03 R21
          next_cur.ch[din[select_high_pos:select_low_pos]].latch =
            live_count[din[select_high_pos:select_low_pos]]; // R02 R04
        end
      end
      else
      begin
        // Control word reprograms the counter and drops its latches
        next_cur.ch[din[select_high_pos:select_low_pos]].mode = din[5:0];
        next_cur.ch[din[select_high_pos:select_low_pos]].null_count = 1'b1; // R13
        next_cur.ch[din[select_high_pos:select_low_pos]].count_latched = 1'b0; // R02
        next_cur.ch[din[select_high_pos:select_low_pos]].status_latched = 1'b0;
        next_cur.ch[din[select_high_pos:select_low_pos]].read_high = 1'b0;
        next_cur.ch[din[select_high_pos:select_low_pos]].write_high = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Strobes idle high, so the filter starts high and no false edge follows reset
      cur <= '0;
      cur.rd_sync <= 3'h7;
      cur.wr_sync <= 3'h7;
      cur.rd_level_n <= 1'b1;
      cur.wr_level_n <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  // Outputs straight from flip-flops
  always_comb
  begin
    port.dev_data = cur.data_out;
    port.dev_data_oe = cur.data_oe;
    for (int i = 0; i < num_counters; i++)
    begin
      count_load_register[i] = cur.ch[i].load_value;
      count_written[i] = cur.ch[i].written;
      mode_bits[i] = cur.ch[i].mode;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/timer_host.sv
// Host end: Avalon-MM slave that runs strobed accesses on the timer port
`timescale 1ns/10ps
`default_nettype none
module timer_host
  import timer_readback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave, address picks the timer port
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer host port
  timer_port_if.host port
);
  typedef struct packed {
    host_state_t st;
    logic [3:0] cnt;
    logic is_read;
    logic [1:0] sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic oe;
    logic wait_req;    // Waitrequest, low only in the release cycle
  } hstate_t;

  hstate_t cur;
  hstate_t next_cur;

  // Sequencer: setup, strobe, recovery, then release waitrequest for one cycle
  always_comb
  begin
    next_cur = cur;
    next_cur.wait_req = 1'b1;
    case (cur.st)
      host_idle:
      begin
        // Read of the command port is a no-operation, still answered
        if (read || write)
        begin
          next_cur.is_read = read; // R19
          next_cur.sel = address;
          next_cur.wdata = writedata[7:0];
          next_cur.cs_n = 1'b0;
          next_cur.oe = write;
          next_cur.cnt = 4'h0;
          next_cur.st = host_setup;
        end
      end
      host_setup:
      begin
        next_cur.rd_n = !cur.is_read;
        next_cur.wr_n = cur.is_read; // R01
        next_cur.cnt = 4'h0;
        next_cur.st = host_strobe;
      end
      host_strobe:
      begin
        next_cur.cnt = cur.cnt + 4'h1;
        if (cur.cnt == strobe_cycles)
        begin
          next_cur.rdata = port.dev_data_oe ? port.dev_data : data_reset;
          next_cur.rd_n = 1'b1;
          next_cur.wr_n = 1'b1;
          next_cur.st = host_done;
        end
      end
      host_done:
      begin
        next_cur.cnt = cur.cnt + 4'h1;
        // Release one cycle ahead so waitrequest itself comes from a flip-flop
        if (cur.cnt == strobe_cycles + strobe_cycles - 4'h1)
          next_cur.wait_req = 1'b0;
        if (cur.cnt == strobe_cycles + strobe_cycles)
        begin
          next_cur.cs_n = 1'b1;
          next_cur.oe = 1'b0;
          next_cur.st = host_idle;
        end
      end
      default: next_cur.st = host_idle;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.cs_n <= 1'b1;
      cur.rd_n <= 1'b1;
      cur.wr_n <= 1'b1;
      cur.wait_req <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  // Outputs from flip-flops; waitrequest low only in the release cycle
  always_comb
  begin
    waitrequest = cur.wait_req;
    readdata = {24'h000000, cur.rdata};
    port.cs_n = cur.cs_n;
    port.rd_n = cur.rd_n;
    port.wr_n = cur.wr_n;
    port.port_select_high = cur.sel[1];
    port.port_select_low = cur.sel[0];
    port.host_data = cur.wdata;
    port.host_data_oe = cur.oe;
  end
endmodule
`default_nettype wire

// >>> tb/timer_port_checker.sv
// Concurrent checks on the parallel host port between the two timer ends
`timescale 1ns/10ps
`default_nettype none
module timer_port_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Strobes and port select
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_select_high,
  input wire logic port_select_low,
  // Data lanes of both ends
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // Command port select code, where a read must stay a no-operation
  logic cmd_sel;
  assign cmd_sel = port_select_high && port_select_low;
  // Never two strobes at once
  strobe_exclusive_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  // A strobe only inside chip select
  strobe_select_a: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe low without chip select");
  // Only one end drives the data lanes
  lanes_exclusive_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data lanes");
  // Device drives only after a selected counter read
  dev_drive_a: assert property (dev_data_oe |-> $past(!cs_n && !rd_n && !cmd_sel))
    else $error("device drives outside a counter read");
  // Host drives only inside its own chip select
  host_drive_a: assert property (host_data_oe |-> (!cs_n || $past(!cs_n)))
    else $error("host drives outside chip select");
  // A counter read is answered within four cycles
  read_answer_a: assert property (($fell(rd_n) && !cmd_sel) |-> ##[1:4] dev_data_oe)
    else $error("counter read not answered in time");
  // Read strobe stands seven cycles
  read_pulse_a: assert property ($fell(rd_n) |-> (!rd_n) [*7] ##1 rd_n)
    else $error("read strobe width wrong");
  // Write strobe stands seven cycles
  write_pulse_a: assert property ($fell(wr_n) |-> (!wr_n) [*7] ##1 wr_n)
    else $error("write strobe width wrong");
  // Write data is held and driven through the strobe
  write_data_a: assert property ((!wr_n && $past(!wr_n)) |-> ($stable(host_data) && host_data_oe))
    else $error("write data moved during strobe");
endmodule
`default_nettype wire

// >>> tb/timer_count_status_readback_tb.sv
// Testbench joining host end and read-back end over the host port
`timescale 1ns/10ps
`default_nettype none
module timer_count_status_readback_tb
  import timer_readback_pkg::*;
;
  logic clk;
  logic reset_n;
  // Avalon side of the host end
  logic [1:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  // Counter side of the device end
  logic [15:0] live_count [num_counters];
  logic [num_counters-1:0] out_level;
  logic [num_counters-1:0] count_loaded;
  logic [15:0] count_load_register [num_counters];
  logic [num_counters-1:0] count_written;
  logic [5:0] mode_bits [num_counters];
  // Expected read bytes, and expected loads as counter, mode and count, oldest first
  logic [7:0] rq [$];
  logic [23:0] cq [$];
  int err_total;
  int cmp_count;
  logic [31:0] rnd;
  logic [15:0] v0;
  logic [15:0] v2;
  timer_port_if port_if();
  timer_host timer_host_i (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .port(port_if.host));
  timer_readback timer_readback_i (.clk(clk), .reset_n(reset_n), .port(port_if.device),
    .live_count(live_count), .out_level(out_level), .count_loaded(count_loaded),
    .count_load_register(count_load_register), .count_written(count_written),
    .mode_bits(mode_bits));
  timer_port_checker timer_port_checker_i (.clk(clk), .reset_n(reset_n), .cs_n(port_if.cs_n),
    .rd_n(port_if.rd_n), .wr_n(port_if.wr_n), .port_select_high(port_if.port_select_high),
    .port_select_low(port_if.port_select_low), .host_data(port_if.host_data),
    .host_data_oe(port_if.host_data_oe), .dev_data(port_if.dev_data),
    .dev_data_oe(port_if.dev_data_oe));
  // Free running 125 MHz clock
  always #4 clk = ~clk;
  // Shift register source of random counts, fixed start
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Prints the counts and verdict, then ends the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compares one read word, a mismatch is reported at once
  task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares one count register load with its counter and mode bits
  task automatic check_load(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Read with its expected byte noted first
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // One cycle pulse of the count moving into the counting element
  task automatic load(input int i);
    @(posedge clk);
    count_loaded[i] <= 1'b1;
    @(posedge clk);
    count_loaded[i] <= 1'b0;
  endtask
  // Watches completed reads and complete count writes of every counter
  always @(posedge clk)
  begin
    if (read && waitrequest === 1'b0)
      check_read(readdata, {24'h000000, rq.pop_front()});
    for (int i = 0; i < num_counters; i++)
      if (count_written[i] === 1'b1)
        check_load({2'(i), mode_bits[i], count_load_register[i]}, cq.pop_front());
  end
  // Bounded run: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    address = 2'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    live_count = '{16'h0, 16'h0, 16'h0};
    count_loaded = 3'h0;
    rnd = lfsr(32'hfb565c38);
    out_level = rnd[2:0];
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    // Program counter 0 for two-byte counts, low byte first
    bus(1'b1, command_port, 8'h34);
    bus(1'b1, port_counter0, 8'h12);
    cq.push_back({2'h0, 6'h34, 16'h3412});
    bus(1'b1, port_counter0, 8'h34);
    load(0);
    // Latch, then a second latch on a moved count is ignored
    v0 = rnd[31:16];
    live_count[0] <= v0;
    bus(1'b1, command_port, 8'h00);
    live_count[0] <= ~v0;
    bus(1'b1, command_port, 8'h00);
    rd(port_counter0, v0[7:0]);
    rd(port_counter0, v0[15:8]);
    rd(port_counter0, ~v0[7:0]);
    rd(port_counter0, ~v0[15:8]);
    // Low byte alone keeps the flag clear, high byte sets it
    bus(1'b1, port_counter0, 8'h55);
    bus(1'b1, command_port, 8'he2);
    rd(port_counter0, {out_level[0], 1'b0, 6'h34});
    cq.push_back({2'h0, 6'h34, 16'h6655});
    bus(1'b1, port_counter0, 8'h66);
    bus(1'b1, command_port, 8'he2);
    rd(port_counter0, {out_level[0], 1'b1, 6'h34});
    rd(port_counter0, ~v0[7:0]);
    rd(port_counter0, ~v0[15:8]);
    load(0);
    // Counter 2 low byte only, then a combined read-back of 0 and 2
    bus(1'b1, command_port, 8'h90);
    cq.push_back({2'h2, 6'h10, 16'h0077});
    bus(1'b1, port_counter2, 8'h77);
    rnd = lfsr(rnd);
    v2 = rnd[15:0];
    live_count[2] <= v2;
    bus(1'b1, command_port, 8'hca);
    // Pins and counts move, so a second capture would show up in the reads
    live_count[0] <= v2;
    live_count[2] <= ~v2;
    out_level <= ~out_level;
    bus(1'b1, command_port, 8'hca);
    rd(port_counter2, {~out_level[2], 1'b1, 6'h10});
    rd(port_counter2, v2[7:0]);
    rd(port_counter0, {~out_level[0], 1'b0, 6'h34});
    rd(port_counter0, ~v0[7:0]);
    // Interleave a write and other ports between the two count bytes
    bus(1'b1, port_counter0, 8'h9a);
    rd(command_port, 8'h00);
    rd(port_counter2, ~v2[7:0]);
    rd(port_counter0, ~v0[15:8]);
    cq.push_back({2'h0, 6'h34, 16'hbc9a});
    bus(1'b1, port_counter0, 8'hbc);
    // Counter 1 high byte only: the write and the read use the upper byte
    bus(1'b1, command_port, 8'h64);
    cq.push_back({2'h1, 6'h24, 16'hab00});
    bus(1'b1, port_counter1, 8'hab);
    rnd = lfsr(rnd);
    live_count[1] <= rnd[15:0];
    rd(port_counter1, rnd[15:8]);
    // Each select bit latches the status of its own counter only
    bus(1'b1, command_port, 8'he2);
    bus(1'b1, command_port, 8'he4);
    bus(1'b1, command_port, 8'he8);
    rd(port_counter1, {out_level[1], 1'b1, 6'h24});
    rd(port_counter2, {out_level[2], 1'b1, 6'h10});
    rd(port_counter0, {out_level[0], 1'b1, 6'h34});
    repeat (4) @(posedge clk);
    // Every noted result must have been seen
    check_load(24'(rq.size() + cq.size()), 24'h000000);
    stop_test();
  end
endmodule
`default_nettype wire
